// file: dio_consts.svh
// Constants for the eight-line digital I/O port: window offsets, field
// positions, reset values and serial timebase figures.
// Assumes it is included by bare name by every file that needs it.
`ifndef DIO_PORT_CONSTS_SVH
`define DIO_PORT_CONSTS_SVH

// ==========================================================================
// Window register numbers.
`define DIO_REG_OUT 16'h000a
`define DIO_REG_DIR 16'h000b
`define DIO_REG_PIN 16'h0003
`define DIO_REG_STAT 16'h0004
`define DIO_REG_CTRL 16'h0047

// ==========================================================================
// Field positions inside the direction and status registers.
`define DIO_BIT_HW_EN 8
`define DIO_BIT_TB_SEL 9
`define DIO_BIT_SW_LVL 10
`define DIO_BIT_START 11
`define DIO_BIT_BUSY 4
`define DIO_LINE_SOUT 0
`define DIO_LINE_SIN 4
`define DIO_SER_LAST 3'h7

// ==========================================================================
// Reset values.
`define DIO_DIR_RST 8'h00
`define DIO_BYTE_RST 8'h00
`define DIO_WORD_RST 16'h0000

// ==========================================================================
// Timebase figures in nanoseconds.
`define DIO_TB_FAST_NS 1200
`define DIO_TB_SLOW_NS 10000
`define DIO_LINK_PERIOD_NS 160
`endif

// file: dio_pkg.sv
// Types shared by the digital I/O port files.
// Assumes nothing beyond a SystemVerilog compiler.
package dio_pkg;

   // ======================================================================
   // One host access to the address/data window pair.
   typedef struct packed {
      logic sel;         // 0 window address, 1 window data.
      logic wr;          // Write strobe.
      logic rd;          // Read strobe.
      logic [15:0] wdata;
   } bus_req_s;

   // ======================================================================
   // Serial engine states, one-hot.
   typedef enum logic [2:0] {
      SER_IDLE = 3'h1,
      SER_LOW = 3'h2,
      SER_HIGH = 3'h4
   } ser_state_e;

endpackage

// file: sync3.sv
// Three-flop synchroniser; the output changes once stages two and three agree.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ns
module sync3 #(
   parameter int W = 1
)(
   input wire logic clk,        // Destination clock.
   input wire logic rst_n,      // Synchronous reset, active low.
   input wire logic ce,         // Clock enable.
   input wire logic [W-1:0] d,  // Asynchronous input.
   output logic [W-1:0] q       // Filtered, synchronised level.
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // Stage one feeds stage two only; q follows when two and three agree.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         q <= '0;
      end else if (ce) begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         q <= (s2 == s3) ? s3 : q;
      end
   end
endmodule

// file: serial_engine.sv
// Serial shifter on the link clock: eight bits out MSB first, eight in.
// Assumes start is a one-cycle pulse and tick a one-cycle timebase pulse.
`timescale 1ns/1ns
`include "dio_consts.svh"
module serial_engine
   import dio_pkg::*;
(
   input wire logic clk,           // Link clock.
   input wire logic rst_n,         // Synchronous reset, active low.
   input wire logic ce,            // Clock enable.
   input wire logic start,         // Begin one byte.
   input wire logic tick,          // Half-bit timebase pulse.
   input wire logic [7:0] tx_byte, // Byte to send.
   input wire logic rx_pin,        // Synchronised serial input.
   output logic busy,              // Transfer in progress.
   output logic sclk_n,            // Active-low bit clock.
   output logic sdout,             // Serial data out.
   output logic [7:0] rx_byte,     // Received byte, first bit in MSB.
   output logic done_tgl           // Toggles at the end of each byte.
);
   ser_state_e state;
   logic [7:0] sh;
   logic [2:0] cnt;

   assign busy = (state != SER_IDLE);

   // Falling edge puts a bit out, rising edge samples the input.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= SER_IDLE;
         sh <= `DIO_BYTE_RST;
         cnt <= '0;
         sclk_n <= 1'b1;
         sdout <= 1'b0;
         rx_byte <= `DIO_BYTE_RST;
         done_tgl <= 1'b0;
      end else if (ce) begin
         case (state)
            SER_IDLE: begin
               if (start) begin
                  sh <= tx_byte;
                  sdout <= tx_byte[7];
                  sclk_n <= 1'b0;
                  cnt <= '0;
                  state <= SER_LOW;
               end
            end
            SER_LOW: begin
               if (tick) begin
                  sclk_n <= 1'b1;
                  rx_byte <= {rx_byte[6:0], rx_pin};
                  state <= SER_HIGH;
               end
            end
            SER_HIGH: begin
               if (tick) begin
                  if (cnt == `DIO_SER_LAST) begin
                     done_tgl <= ~done_tgl;
                     state <= SER_IDLE;
                  end else begin
                     cnt <= cnt + 3'h1;
                     sh <= {sh[6:0], 1'b0};
                     sdout <= sh[6];
                     sclk_n <= 1'b0;
                     state <= SER_LOW;
                  end
               end
            end
            default: begin
               state <= SER_IDLE;
               sclk_n <= 1'b1;
            end
         endcase
      end
   end
endmodule

// file: dio_port.sv
// Eight-line bidirectional digital I/O port with serial shifter, control
// strobes and board status inputs, reached through an address/data window.
// Assumes host software on clk_sys and a free-running serial timebase clock.
//
// Function
// - Each line has a direction bit; 0 input, 1 driven output.
// - Lines are set independently, any mix of inputs and outputs.
// - Direction bit 7 controls line 7, down to bit 0 for line 0.
// - Line 4 serves as serial input, line 0 as serial output, byte wide.
// - Strobe pin is active low: serial clock, strobe or plain output.
// - In software mode the strobe pin follows a written level bit.
// - In hardware mode the strobe pin carries the serial bit clock.
// - Serial clock runs at one of two rates picked by a timebase bit.
// - Eight control outputs follow a software-written control field.
// - Four status inputs are sampled into a readable status field.
// - Writing 0xff to the direction register makes all lines outputs.
// - Output register writes set levels on lines configured as outputs, line 0 only in software mode.
// - Host writes a register number, then a 16-bit data access.
// - Hardware serial clock uses the 1.2 us or 10 us timebase.
// - Parallel read returns pin level for inputs, output register value for outputs.
// - Serial output shifts most significant bit first.
// - A transfer gives exactly eight clocks and starts on software command.
`timescale 1ns/1ns
`include "dio_consts.svh"
module dio_port
   import dio_pkg::*;
#(
   parameter int LINK_NS = `DIO_LINK_PERIOD_NS, // Link clock period.
   parameter int FAST_NS = `DIO_TB_FAST_NS,     // Fast timebase.
   parameter int SLOW_NS = `DIO_TB_SLOW_NS      // Slow timebase.
)(
   input wire logic clk_sys,                // System clock, 100 MHz.
   input wire logic resetn,                 // Synchronous reset, active low.
   input wire logic ce,                     // Clock enable, freezes state.
   input wire logic clk_link,               // Serial timebase clock.
   input wire bus_req_s bus_req,            // Window access request.
   output logic [15:0] bus_rdata,           // Read data, registered.
   input wire logic [7:0] dio_in,           // Port line levels.
   output logic [7:0] dio_out,              // Port line drive values.
   output logic [7:0] dio_oe_n,             // Line drive enables, low drives.
   output logic strobe_serial_clock_pin_n,  // Strobe or serial clock.
   output logic [7:0] ctrl_out,             // Control strobe lines.
   input wire logic [3:0] board_status_in   // Board status lines.
);

   // ======================================================================
   // Timebase counts in link clock cycles, rounded down, never below one.
   localparam int FAST_RAW = FAST_NS / LINK_NS;
   localparam int SLOW_RAW = SLOW_NS / LINK_NS;
   localparam int FAST_CYC = (FAST_RAW < 1) ? 1 : FAST_RAW;
   localparam int SLOW_CYC = (SLOW_RAW < 1) ? 1 : SLOW_RAW;
   localparam logic [15:0] FAST_MAX = 16'(FAST_CYC - 1);
   localparam logic [15:0] SLOW_MAX = 16'(SLOW_CYC - 1);

   // ======================================================================
   // System-domain registers.
   logic [15:0] win_addr;
   logic [7:0] parallel_output_field;
   logic [7:0] serial_output_byte;
   logic [7:0] line_direction_field;
   logic hardware_serial_clock_enable;
   logic serial_timebase_select;
   logic software_strobe_level;
   logic start_tgl;
   logic sys_busy;
   logic [7:0] serial_input_byte;
   logic [3:0] board_status_field;
   logic done_seen;

   // Synchronised inputs in the system domain.
   logic [7:0] pin_sync;
   logic [3:0] status_sync;
   logic [1:0] back_sync;

   // ======================================================================
   // Link-domain signals.
   logic link_rst_n;
   logic link_ce;
   logic [2:0] fwd_sync;
   logic start_seen;
   logic sin_sync;
   logic [15:0] div_cnt;
   logic tick;
   logic eng_busy;
   logic eng_sclk_n;
   logic eng_sdout;
   logic [7:0] eng_rx;
   logic eng_done_tgl;

   // ======================================================================
   // Window decode.
   wire addr_wr = ce & bus_req.wr & ~bus_req.sel;
   wire data_wr = ce & bus_req.wr & bus_req.sel;
   wire data_rd = bus_req.rd & bus_req.sel;
   wire hit_out = data_wr & (win_addr == `DIO_REG_OUT);
   wire hit_dir = data_wr & (win_addr == `DIO_REG_DIR);
   wire hit_ctrl = data_wr & (win_addr == `DIO_REG_CTRL);
   wire start_req = hit_dir & bus_req.wdata[`DIO_BIT_START];

   // Start is refused while a byte is still moving or without the clock mode.
   wire start_go = start_req & bus_req.wdata[`DIO_BIT_HW_EN] & ~sys_busy;

   // Done toggle edge; bit one of the back path is the busy level.
   wire done_edge = back_sync[0] ^ done_seen;

   // ======================================================================
   // Readback values.
   wire [7:0] parallel_input_field =
      (line_direction_field & parallel_output_field) |
      (~line_direction_field & pin_sync);
   wire [15:0] rd_pin = {serial_input_byte, parallel_input_field};
   wire [15:0] rd_stat = {11'h000, sys_busy, board_status_field};
   wire [15:0] rd_data =
      (win_addr == `DIO_REG_PIN) ? rd_pin :
      (win_addr == `DIO_REG_STAT) ? rd_stat : `DIO_WORD_RST;
   wire [15:0] next_rdata = data_rd ? rd_data : win_addr;

   // ======================================================================
   // Pin drive.
   assign dio_oe_n = ~line_direction_field;
   assign dio_out[7:1] = parallel_output_field[7:1];
   assign dio_out[`DIO_LINE_SOUT] = hardware_serial_clock_enable ?
      eng_sdout : parallel_output_field[`DIO_LINE_SOUT];
   assign strobe_serial_clock_pin_n = hardware_serial_clock_enable ?
      eng_sclk_n : software_strobe_level;

   // ======================================================================
   // Input synchronisers for the pins in the system domain.
   sync3 #(.W(8)) u_pin_sync (
      .clk(clk_sys),
      .rst_n(resetn),
      .ce(ce),
      .d(dio_in),
      .q(pin_sync)
   );

   sync3 #(.W(4)) u_status_sync (
      .clk(clk_sys),
      .rst_n(resetn),
      .ce(ce),
      .d(board_status_in),
      .q(status_sync)
   );

   // Busy level and done toggle coming back from the link domain.
   sync3 #(.W(2)) u_back_sync (
      .clk(clk_sys),
      .rst_n(resetn),
      .ce(ce),
      .d({eng_busy, eng_done_tgl}),
      .q(back_sync)
   );

   // ======================================================================
   // Window address register.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         win_addr <= `DIO_WORD_RST;
      end else if (addr_wr) begin
         win_addr <= bus_req.wdata;
      end
   end

   // Output register: parallel field low, serial byte high.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         parallel_output_field <= `DIO_BYTE_RST;
         serial_output_byte <= `DIO_BYTE_RST;
      end else if (hit_out) begin
         parallel_output_field <= bus_req.wdata[7:0];
         serial_output_byte <= bus_req.wdata[15:8];
      end
   end

   // Direction register and serial mode bits.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         line_direction_field <= `DIO_DIR_RST;
         hardware_serial_clock_enable <= 1'b0;
         serial_timebase_select <= 1'b0;
         software_strobe_level <= 1'b1;
      end else if (hit_dir) begin
         line_direction_field <= bus_req.wdata[7:0];
         hardware_serial_clock_enable <= bus_req.wdata[`DIO_BIT_HW_EN];
         serial_timebase_select <= bus_req.wdata[`DIO_BIT_TB_SEL];
         software_strobe_level <= bus_req.wdata[`DIO_BIT_SW_LVL];
      end
   end

   // Control strobe lines.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ctrl_out <= `DIO_BYTE_RST;
      end else if (hit_ctrl) begin
         ctrl_out <= bus_req.wdata[15:8];
      end
   end

   // Start toggle and busy flag; the start request wins over completion.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         start_tgl <= 1'b0;
         sys_busy <= 1'b0;
         done_seen <= 1'b0;
      end else if (ce) begin
         done_seen <= back_sync[0];
         if (start_go) begin
            start_tgl <= ~start_tgl;
            sys_busy <= 1'b1;
         end else if (done_edge) begin
            sys_busy <= 1'b0;
         end
      end
   end

   // Received byte is stable in the link domain once done has toggled.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         serial_input_byte <= `DIO_BYTE_RST;
      end else if (ce & done_edge) begin
         serial_input_byte <= eng_rx;
      end
   end

   // Status sampling and read data.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         board_status_field <= 4'h0;
         bus_rdata <= `DIO_WORD_RST;
      end else if (ce) begin
         board_status_field <= status_sync;
         bus_rdata <= next_rdata;
      end
   end

   // ======================================================================
   // Link-domain reset and clock enable.
   sync3 #(.W(2)) u_link_ctl (
      .clk(clk_link),
      .rst_n(1'b1),
      .ce(1'b1),
      .d({resetn, ce}),
      .q({link_rst_n, link_ce})
   );

   // Mode bits and start toggle into the link domain.
   sync3 #(.W(3)) u_fwd_sync (
      .clk(clk_link),
      .rst_n(link_rst_n),
      .ce(link_ce),
      .d({hardware_serial_clock_enable, serial_timebase_select, start_tgl}),
      .q(fwd_sync)
   );

   // Serial input line, sampled in the link domain.
   sync3 #(.W(1)) u_sin_sync (
      .clk(clk_link),
      .rst_n(link_rst_n),
      .ce(link_ce),
      .d(dio_in[`DIO_LINE_SIN]),
      .q(sin_sync)
   );

   wire link_start = (fwd_sync[0] ^ start_seen) & fwd_sync[2];
   wire [15:0] div_max = fwd_sync[1] ? SLOW_MAX : FAST_MAX;

   // Timebase divider; held clear while idle so each phase is full length.
   always_ff @(posedge clk_link) begin
      if (!link_rst_n) begin
         div_cnt <= 16'h0000;
         tick <= 1'b0;
         start_seen <= 1'b0;
      end else if (link_ce) begin
         start_seen <= fwd_sync[0];
         if (!eng_busy || div_cnt >= div_max) begin
            div_cnt <= 16'h0000;
         end else begin
            div_cnt <= div_cnt + 16'h0001;
         end
         tick <= eng_busy & (div_cnt >= div_max);
      end
   end

   // ======================================================================
   // Serial shifter.
   serial_engine u_engine (
      .clk(clk_link),
      .rst_n(link_rst_n),
      .ce(link_ce),
      .start(link_start),
      .tick(tick),
      .tx_byte(serial_output_byte),
      .rx_pin(sin_sync),
      .busy(eng_busy),
      .sclk_n(eng_sclk_n),
      .sdout(eng_sdout),
      .rx_byte(eng_rx),
      .done_tgl(eng_done_tgl)
   );

endmodule

// file: dio_port_checker.sv
// Concurrent checks on the window registers and lines of dio_port.
// Assumes it is bound to dio_port and sees only its ports.
`timescale 1ns/1ns
module dio_port_checker
   import dio_pkg::*;
(
   input wire logic clk_sys, // System clock.
   input wire logic resetn, // Reset, active low.
   input wire logic ce, // Clock enable.
   input wire bus_req_s bus_req, // Window request.
   input wire logic [15:0] bus_rdata, // Read data.
   input wire logic [7:0] dio_in, // Line levels.
   input wire logic [7:0] dio_out, // Drive values.
   input wire logic [7:0] dio_oe_n, // Drive enables.
   input wire logic strobe_serial_clock_pin_n, // Strobe pin.
   input wire logic [7:0] ctrl_out, // Control lines.
   input wire logic [3:0] board_status_in // Status lines.
);
   logic [15:0] addr;
   logic [3:0] quiet;
   // ==========================================================================
   // Window decode and the line value a parallel read should return.
   wire take_wr = ce && bus_req.sel && bus_req.wr;
   wire take_rd = ce && bus_req.sel && bus_req.rd;
   wire [15:0] wd = bus_req.wdata;
   wire [7:0] pin_exp = (dio_oe_n & dio_in) | (~dio_oe_n & dio_out);
   // ==========================================================================
   // Window address copy and a count of cycles with unchanged inputs.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         addr <= 16'h0000;
         quiet <= 4'h0;
      end else begin
         if (ce && !bus_req.sel && bus_req.wr) begin
            addr <= wd;
         end
         if ({dio_in, board_status_in} != $past({dio_in, board_status_in})) begin
            quiet <= 4'h0;
         end else if (quiet != 4'hf) begin
            quiet <= quiet + 4'h1;
         end
      end
   end
   // ==========================================================================
   // Data accesses to one window register number.
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   sequence data_wr(logic [15:0] a);
      take_wr && addr == a;
   endsequence
   sequence data_rd(logic [15:0] a);
      take_rd && addr == a;
   endsequence
   chk_reset_idle: assert property (
      $rose(resetn) |-> dio_oe_n == 8'hff && ctrl_out == 8'h00 && strobe_serial_clock_pin_n)
      else $error("outputs not idle after reset");
   chk_dir_write: assert property (
      data_wr(16'h000b) |=> dio_oe_n == ~$past(wd[7:0]))
      else $error("direction write lost");
   chk_out_write: assert property (
      data_wr(16'h000a) |=> dio_out[7:1] == $past(wd[7:1]))
      else $error("output write lost");
   chk_ctrl_write: assert property (
      data_wr(16'h0047) |=> ctrl_out == $past(wd[15:8]))
      else $error("control write lost");
   chk_sw_strobe: assert property (
      data_wr(16'h000b) ##0 !wd[8] |=> strobe_serial_clock_pin_n == $past(wd[10]))
      else $error("strobe ignores level bit");
   chk_status_read: assert property (
      data_rd(16'h0004) ##0 quiet > 4'h7 |=> bus_rdata[3:0] == $past(board_status_in))
      else $error("status read wrong");
   chk_pin_read: assert property (
      data_rd(16'h0003) ##0 quiet > 4'h7 |=> bus_rdata[7:1] == $past(pin_exp[7:1]))
      else $error("line read wrong");
   chk_void_read: assert property (
      take_rd && addr != 16'h0003 && addr != 16'h0004 |=> bus_rdata == 16'h0000)
      else $error("unmapped read not zero");
endmodule
bind dio_port dio_port_checker i_chk (.clk_sys, .resetn, .ce, .bus_req, .bus_rdata, .dio_in,
   .dio_out, .dio_oe_n, .strobe_serial_clock_pin_n, .ctrl_out, .board_status_in);

// file: dio_partner.sv
// Far-side device: drives input lines, pull-ups elsewhere, serial peer.
// Assumes a new bit is due on line 4 after each strobe fall.
`timescale 1ns/1ns
module dio_partner (
   input wire logic [7:0] dio_out, // Port drive values.
   input wire logic [7:0] dio_oe_n, // Port drive enables, low drives.
   input wire logic strobe_n, // Strobe pin.
   input wire logic [7:0] ext_val, // Levels driven here.
   input wire logic [7:0] ext_en, // Lines driven here.
   input wire logic ser_on, // Serial peer on; a rise clears counts.
   input wire logic [7:0] tx_byte, // Byte sent on line 4.
   output logic [7:0] dio_in, // Resolved line levels.
   output logic [7:0] rx_byte, // Byte taken from line 0.
   output int n_rise, // Strobe rises seen.
   output realtime t_bit // Time between first two falls.
);
   logic sdin = 1'b1;
   int n_fall = 0;
   realtime t_fall = 0;
   // ==========================================================================
   // Serial peer: next bit after each fall, line 0 taken on each rise.
   initial begin
      rx_byte = 8'h00;
      t_bit = 0;
   end
   always @(posedge ser_on) begin
      n_rise = 0;
      n_fall = 0;
   end
   always @(negedge strobe_n) begin
      if (n_fall < 8) sdin = tx_byte[7 - n_fall];
      if (n_fall == 1) t_bit = $realtime - t_fall;
      t_fall = $realtime;
      n_fall++;
   end
   always @(posedge strobe_n) begin
      rx_byte = {rx_byte[6:0], dio_out[0]};
      n_rise++;
      if (n_rise == 8) sdin = ~sdin; // Stale bit goes inverted.
   end
   // Port drive wins, a clash is unknown, else this device or the pull-up.
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!dio_oe_n[i]) dio_in[i] = ext_en[i] ? 1'bx : dio_out[i];
         else if (ser_on && i == 4) dio_in[i] = sdin;
         else if (ext_en[i]) dio_in[i] = ext_val[i];
         else dio_in[i] = 1'b1;
      end
   end
endmodule

// file: dio_port_test.sv
// Self-checking bench for dio_port: registers, lines, strobe and serial.
// Assumes dio_partner stands for the far side of the lines.
`timescale 1ns/1ns
`include "dio_consts.svh"
module dio_port_test;
   import dio_pkg::*;
   localparam int FAST = 1200; // Fast timebase in ns.
   localparam int SLOW = 10000; // Slow timebase in ns.
   logic clk_sys, clk_link, resetn, ce, strobe, ser_on;
   bus_req_s bus_req;
   logic [15:0] bus_rdata, q, cfg;
   logic [7:0] dio_in, dio_out, dio_oe_n, ctrl_out, ext_val, ext_en, rx_byte, dir, pout, c, txp;
   logic [3:0] status;
   int failures, n_compared, n_rise, span;
   realtime t_bit;
   // ==========================================================================
   // Design and far side.
   dio_port #(.LINK_NS(160), .FAST_NS(FAST), .SLOW_NS(SLOW)) i_dut (.clk_sys, .resetn, .ce,
      .clk_link, .bus_req, .bus_rdata, .dio_in, .dio_out, .dio_oe_n,
      .strobe_serial_clock_pin_n(strobe), .ctrl_out, .board_status_in(status));
   dio_partner i_far (.dio_out, .dio_oe_n, .strobe_n(strobe), .ext_val, .ext_en, .ser_on,
      .tx_byte(txp), .dio_in, .rx_byte, .n_rise, .t_bit);
   // Clocks at 10 ns and 160 ns, the second with its own phase.
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      clk_link = 1'b0;
      #3;
      forever #80 clk_link = ~clk_link;
   end
   // Watchdog: the whole run needs well under 0.4 ms.
   initial begin
      #400_000;
      failures++;
      summarize();
   end
   // ==========================================================================
   // Compare, report and window access tasks.
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic acc(input logic sel, input logic wr, input logic [15:0] d);
      @(negedge clk_sys);
      bus_req = '{sel, wr, !wr, d};
      @(negedge clk_sys);
      q = bus_rdata;
      bus_req = '0;
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
      acc(1'b0, 1'b1, a);
      acc(1'b1, 1'b1, d);
   endtask
   task automatic rd_reg(input logic [15:0] a);
      acc(1'b0, 1'b1, a);
      acc(1'b1, 1'b0, 16'h0000);
   endtask
   // ==========================================================================
   // Main sequence.
   initial begin
      failures = 0;
      n_compared = 0;
      {resetn, ser_on, ext_val, ext_en, status, txp} = '0;
      ce = 1'b1;
      bus_req = '0;
      void'($urandom(2078));
      repeat (5) @(posedge clk_link);
      @(negedge clk_sys);
      resetn = 1'b1;
      check({dio_oe_n, ctrl_out}, 16'hff00);
      check({dio_out, 7'h00, strobe}, 16'h0001);
      // Directions, drive values and read-back; all lines out first.
      for (int k = 0; k < 6; k++) begin
         dir = (k == 0) ? 8'hff : 8'($urandom);
         pout = 8'($urandom);
         ext_en = ext_en & ~dir;
         wr_reg(`DIO_REG_DIR, {8'h04, dir});
         ext_val = 8'($urandom);
         ext_en = ~dir;
         wr_reg(`DIO_REG_OUT, {8'h00, pout});
         check({dio_oe_n, dio_out}, {~dir, pout});
         repeat (8) @(negedge clk_sys);
         rd_reg(`DIO_REG_PIN);
         check(16'(q[7:0]), 16'((dir & pout) | (~dir & ext_val)));
      end
      // Control lines and board status.
      for (int k = 0; k < 4; k++) begin
         c = 8'($urandom);
         status = 4'($urandom);
         wr_reg(`DIO_REG_CTRL, {c, 8'h00});
         check(16'(ctrl_out), 16'(c));
         repeat (8) @(negedge clk_sys);
         rd_reg(`DIO_REG_STAT);
         check(16'(q[4:0]), {12'h000, status});
      end
      // A write made while the clock enable is low must change nothing.
      ce = 1'b0;
      wr_reg(`DIO_REG_CTRL, {~c, 8'h00});
      ce = 1'b1;
      check(16'(ctrl_out), 16'(c));
      // Unmapped and write-only reads come back empty.
      rd_reg(16'h0055);
      check(q, 16'h0000);
      rd_reg(`DIO_REG_OUT);
      check(q, 16'h0000);
      // Software strobe level, low then high.
      for (int k = 0; k < 2; k++) begin
         wr_reg(`DIO_REG_DIR, {5'h00, k[0], 10'h000});
         check(16'(strobe), 16'(k));
      end
      // Serial transfers at both rates, each with a second start while busy.
      ext_en = 8'h00;
      for (int k = 0; k < 2; k++) begin
         pout = 8'($urandom);
         txp = 8'($urandom);
         cfg = {5'h00, 1'b1, k[0], 1'b1, 8'h01};
         wr_reg(`DIO_REG_OUT, {pout, 8'h00});
         ser_on = 1'b1;
         wr_reg(`DIO_REG_DIR, cfg);
         repeat (6) @(posedge clk_link);
         wr_reg(`DIO_REG_DIR, cfg | 16'h0800);
         repeat (300) @(negedge clk_sys);
         wr_reg(`DIO_REG_DIR, cfg | 16'h0800);
         q = 16'h0010;
         for (int n = 0; n < 8000 && q[4]; n++) rd_reg(`DIO_REG_STAT);
         check(16'(q[4]), 16'h0000);
         repeat (20) @(negedge clk_sys);
         check({rx_byte, 7'h00, strobe}, {pout, 8'h01});
         check(16'(n_rise), 16'h0008);
         rd_reg(`DIO_REG_PIN);
         check(16'(q[15:8]), 16'(txp));
         span = 2 * (k ? SLOW : FAST);
         check(16'(t_bit > span * 0.75 - 640 && t_bit < span * 1.25 + 640), 16'h0001);
         ser_on = 1'b0;
      end
      summarize();
   end
endmodule
